// file: i2c_bridge_pkg.sv
// Purpose: Shared constants and types of the I2C slave bridge
// Assumes: Buffer depths are powers of two
// Notes: Command codes follow a general call address byte
package i2c_bridge_pkg;
	// Buffer sizes and counter widths
	localparam int TX_DEPTH = 512;
	localparam int RX_DEPTH = 512;
	localparam int TX_CNT_W = $clog2(TX_DEPTH + 1);
	localparam int RX_CNT_W = $clog2(RX_DEPTH + 1);
	localparam int ADDR_W = 10;

	// Address bytes and general call commands
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [4:0] ADDR10_HDR = 5'h1E;
	localparam logic [7:0] CMD_SOFT_RESET = 8'h06;
	localparam logic [7:0] CMD_FLUSH = 8'h0E;
	localparam logic [7:0] CMD_DATA_AVAIL = 8'h0C;

	// Data-available saturation
	localparam int SAT_LIMIT = 255;
	localparam logic [7:0] SAT_VALUE = 8'hFF;
	localparam logic [7:0] EMPTY_FILL = 8'hFF;

	// Bit counter marks and reset values
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_DONE = 4'h8;
	localparam logic BUS_IDLE = 1'b1;

	// Configurable pin sources
	localparam logic [1:0] PIN_TX_STATUS = 2'h0;
	localparam logic [1:0] PIN_RX_STATUS = 2'h1;

	// Bus phase
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RX = 6'h02,
		ST_ACK = 6'h04,
		ST_ACKH = 6'h08,
		ST_TX = 6'h10,
		ST_MACK = 6'h20
	} state_t;

	// Meaning of the byte being received
	typedef enum logic [3:0] {
		K_ADDR = 4'h1,
		K_ADDR2 = 4'h2,
		K_CMD = 4'h4,
		K_DATA = 4'h8
	} kind_t;
endpackage : i2c_bridge_pkg

// file: byte_fifo.sv
// Purpose: Byte buffer with occupancy count and synchronous flush
// Assumes: DEPTH is a power of two so pointers wrap by overflow
// Notes: Flush wins over push and pop in the same cycle
`timescale 1ns/1ns
module byte_fifo #(
	parameter int DEPTH = i2c_bridge_pkg::TX_DEPTH
) (
	input wire logic clk_i, // System clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic flush_i, // Empty the buffer
	input wire logic wr_valid_i, // Write request
	output logic wr_ready_o, // Space available
	input wire logic [7:0] wr_data_i, // Write byte
	output logic rd_valid_o, // Data available
	input wire logic rd_ready_i, // Read accept
	output logic [7:0] rd_data_o, // Head byte
	output logic [$clog2(DEPTH+1)-1:0] count_o // Occupancy
);
	import i2c_bridge_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [7:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [CW-1:0] count_q;
	logic push;
	logic pop;

	// Handshake and head data
	assign wr_ready_o = count_q != CW'(DEPTH);
	assign rd_valid_o = count_q != '0;
	assign rd_data_o = mem_q[rd_ptr_q];
	assign count_o = count_q;
	assign push = wr_valid_i && wr_ready_o && !flush_i;
	assign pop = rd_valid_o && rd_ready_i && !flush_i;

	// Storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= wr_data_i;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else if (flush_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) wr_ptr_q <= wr_ptr_q + AW'(1);
			if (pop) rd_ptr_q <= rd_ptr_q + AW'(1);
			case ({push, pop})
				2'b10: count_q <= count_q + CW'(1);
				2'b01: count_q <= count_q - CW'(1);
				default: count_q <= count_q;
			endcase
		end
	end

	// Occupancy never exceeds depth
	count_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) count_q <= CW'(DEPTH))
		else $error("buffer count above depth");
endmodule : byte_fifo

// file: i2c_slave_fifo_bridge.sv
// Purpose: I2C slave front end moving bytes between an I2C master and two USB-side buffers
// Assumes: scl_i and sda_i are already synchronous to clk_i
// Notes: SDA is open drain, sda_oe_o high pulls the line low
// Summary of operation
// - Slave only; matches stored address, 7-bit or 10-bit mode.
// - Acknowledge general call, treat next byte as a command.
// - 10-bit header 11110XX plus second byte; repeated start allows combined read.
// - Command 0x0C makes the next read return the transmit buffer count.
// - That count saturates at 0xFF for 255 or more bytes.
// - Read bytes come in order from the transmit buffer.
// - Read address is not acknowledged when transmit buffer is empty and no count read is pending.
// - Transmit status pin active while buffer holds data, routable, no count.
// - Written bytes enter the receive buffer in order.
// - Receive status pin active while a free location exists, routable.
// - Write address is not acknowledged when receive buffer is full.
// - Data bytes that cannot be stored are not acknowledged and dropped.
// - No command reports receive space; per-byte acknowledge is flow control.
// - Acknowledge is low, not-acknowledge high, in the ninth clock.
// - Command 0x06 is a software reset clearing all buffers.
// - Command 0x0E flushes both buffers.
`timescale 1ns/1ns
module i2c_slave_fifo_bridge (
	input wire logic clk_i, // 100 MHz system clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic scl_i, // I2C clock level
	input wire logic sda_i, // I2C data level
	output logic sda_o, // Data drive value, always low
	output logic sda_oe_o, // Pull SDA low when high
	input wire logic [i2c_bridge_pkg::ADDR_W-1:0] slave_addr_i, // Address from nonvolatile_config_store
	input wire logic addr_10bit_i, // Use 10-bit addressing
	input wire logic [1:0] io_pin_sel_i, // Source of configurable_io_pin_o
	input wire logic usb_tx_valid_i, // USB byte to send to master
	output logic usb_tx_ready_o, // Transmit buffer has space
	input wire logic [7:0] usb_tx_data_i, // USB byte
	output logic usb_rx_valid_o, // Received byte available
	input wire logic usb_rx_ready_i, // USB side takes byte
	output logic [7:0] usb_rx_data_o, // Received byte
	output logic tx_buffer_has_data_n_o, // Low while transmit buffer non-empty
	output logic rx_buffer_has_space_n_o, // Low while receive buffer has room
	output logic configurable_io_pin_o // Routed status
);
	import i2c_bridge_pkg::*;

	state_t state_q;
	kind_t kind_q;
	kind_t dec_kind;
	logic scl_q, sda_q;
	logic scl_rise, scl_fall, start_w, stop_w;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q, byte_w, tx_byte_w, sat_w;
	logic oe_q, ack_q, rw_q, a10_sel_q, query_q;
	logic dec_evt, dec_ack, dec_rw, dec_a10, dec_push, dec_flush, dec_query;
	logic tx_load, tx_pop, tx_valid, rx_space, flush_w;
	logic [7:0] tx_head;
	logic [TX_CNT_W-1:0] tx_count;
	logic [RX_CNT_W-1:0] rx_count;
	logic tx_stat_n_q, rx_stat_n_q, pin_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// Line edges and bus conditions
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_q <= BUS_IDLE;
			sda_q <= BUS_IDLE;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end
	assign scl_rise = scl_i && !scl_q;
	assign scl_fall = !scl_i && scl_q;
	assign start_w = scl_i && scl_q && sda_q && !sda_i;
	assign stop_w = scl_i && scl_q && !sda_q && sda_i;

	// Byte complete at the eighth rising clock
	assign byte_w = {shift_q[6:0], sda_i};
	assign dec_evt = (state_q == ST_RX) && scl_rise && (bit_cnt_q == BIT_LAST);

	// Decode of the completed byte
	always_comb begin
		dec_ack = 1'b0;
		dec_kind = K_DATA;
		dec_rw = rw_q;
		dec_a10 = a10_sel_q;
		dec_push = 1'b0;
		dec_flush = 1'b0;
		dec_query = query_q;
		case (kind_q)
			K_ADDR: begin
				if (byte_w == GC_ADDR) begin
					dec_ack = 1'b1;
					dec_kind = K_CMD;
					dec_rw = 1'b0;
				end else if (!addr_10bit_i && byte_w[7:1] == slave_addr_i[6:0]) begin
					dec_rw = byte_w[0];
					dec_ack = byte_w[0] ? (query_q || tx_valid) : rx_space;
				end else if (addr_10bit_i && byte_w[7:3] == ADDR10_HDR && byte_w[2:1] == slave_addr_i[9:8]) begin
					if (!byte_w[0]) begin
						dec_ack = 1'b1;
						dec_kind = K_ADDR2;
						dec_rw = 1'b0;
					end else if (a10_sel_q) begin
						dec_rw = 1'b1;
						dec_ack = query_q || tx_valid;
					end
				end
			end
			K_ADDR2: begin
				dec_a10 = byte_w == slave_addr_i[7:0];
				dec_ack = dec_a10 && rx_space;
			end
			K_CMD: begin
				dec_ack = 1'b1;
				dec_kind = K_CMD;
				dec_flush = byte_w == CMD_SOFT_RESET || byte_w == CMD_FLUSH;
				dec_query = query_q || byte_w == CMD_DATA_AVAIL;
			end
			K_DATA: begin
				dec_ack = rx_space;
				dec_push = rx_space;
			end
			default: dec_ack = 1'b0;
		endcase
	end
	assign flush_w = dec_evt && dec_flush;

	// Byte offered to the master on a read
	assign sat_w = (tx_count >= TX_CNT_W'(SAT_LIMIT)) ? SAT_VALUE : tx_count[7:0];
	assign tx_byte_w = query_q ? sat_w : (tx_valid ? tx_head : EMPTY_FILL);
	assign tx_load = scl_fall && ((state_q == ST_ACKH && ack_q && rw_q) || state_q == ST_MACK);
	assign tx_pop = tx_load && !query_q && tx_valid;

	// Bus phase, bit counter and shifting
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			kind_q <= K_ADDR;
			bit_cnt_q <= '0;
			shift_q <= '0;
			oe_q <= 1'b0;
			ack_q <= 1'b0;
			rw_q <= 1'b0;
		end else if (start_w) begin
			state_q <= ST_RX;
			kind_q <= K_ADDR;
			bit_cnt_q <= '0;
			oe_q <= 1'b0;
		end else if (stop_w) begin
			state_q <= ST_IDLE;
			oe_q <= 1'b0;
		end else begin
			case (state_q)
				ST_RX: if (scl_rise) begin
					shift_q <= byte_w;
					bit_cnt_q <= bit_cnt_q + 4'h1;
					if (dec_evt) begin
						state_q <= ST_ACK;
						ack_q <= dec_ack;
						rw_q <= dec_rw;
						kind_q <= dec_kind;
					end
				end
				ST_ACK: if (scl_fall) begin
					oe_q <= ack_q;
					state_q <= ST_ACKH;
				end
				ST_ACKH: if (scl_fall) begin
					if (tx_load) begin
						oe_q <= ~tx_byte_w[7];
						shift_q <= {tx_byte_w[6:0], 1'b0};
						bit_cnt_q <= 4'h1;
						state_q <= ST_TX;
					end else begin
						oe_q <= 1'b0;
						bit_cnt_q <= '0;
						state_q <= ack_q ? ST_RX : ST_IDLE;
					end
				end
				ST_TX: if (scl_fall) begin
					if (bit_cnt_q == BIT_DONE) begin
						oe_q <= 1'b0;
						state_q <= ST_MACK;
					end else begin
						oe_q <= ~shift_q[7];
						shift_q <= {shift_q[6:0], 1'b0};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
				end
				ST_MACK: begin
					if (scl_rise && sda_i) begin
						state_q <= ST_IDLE;
					end else if (tx_load) begin
						oe_q <= ~tx_byte_w[7];
						shift_q <= {tx_byte_w[6:0], 1'b0};
						bit_cnt_q <= 4'h1;
						state_q <= ST_TX;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// 10-bit selection survives repeated start, ends at stop
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			a10_sel_q <= 1'b0;
		end else if (stop_w) begin
			a10_sel_q <= 1'b0;
		end else if (dec_evt && kind_q == K_ADDR2) begin
			a10_sel_q <= dec_a10;
		end
	end

	// Pending data-available answer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			query_q <= 1'b0;
		end else if (tx_load && query_q) begin
			query_q <= 1'b0;
		end else if (dec_evt) begin
			query_q <= dec_query;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_o = oe_q;

	// Buffers toward and from the USB side
	byte_fifo #(.DEPTH(TX_DEPTH)) u_tx_fifo (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .flush_i(flush_w),
		.wr_valid_i(usb_tx_valid_i), .wr_ready_o(usb_tx_ready_o), .wr_data_i(usb_tx_data_i),
		.rd_valid_o(tx_valid), .rd_ready_i(tx_pop), .rd_data_o(tx_head), .count_o(tx_count)
	);
	byte_fifo #(.DEPTH(RX_DEPTH)) u_rx_fifo (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .flush_i(flush_w),
		.wr_valid_i(dec_evt && dec_push), .wr_ready_o(rx_space), .wr_data_i(byte_w),
		.rd_valid_o(usb_rx_valid_o), .rd_ready_i(usb_rx_ready_i), .rd_data_o(usb_rx_data_o), .count_o(rx_count)
	);

	// Status outputs and configurable pin
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_stat_n_q <= 1'b1;
			rx_stat_n_q <= 1'b1;
			pin_q <= 1'b1;
		end else begin
			tx_stat_n_q <= !tx_valid;
			rx_stat_n_q <= !rx_space;
			case (io_pin_sel_i)
				PIN_TX_STATUS: pin_q <= !tx_valid;
				PIN_RX_STATUS: pin_q <= !rx_space;
				default: pin_q <= 1'b1;
			endcase
		end
	end
	assign tx_buffer_has_data_n_o = tx_stat_n_q;
	assign rx_buffer_has_space_n_o = rx_stat_n_q;
	assign configurable_io_pin_o = pin_q;

	// Checks
	read_nack_empty_a: assert property (dec_evt && kind_q == K_ADDR && dec_rw && !query_q && !tx_valid |=> !ack_q)
		else $error("read address acknowledged with empty buffer");
	write_nack_full_a: assert property (dec_evt && kind_q == K_ADDR && !addr_10bit_i && !byte_w[0] && byte_w[7:1] == slave_addr_i[6:0] && !rx_space |=> !ack_q)
		else $error("write address acknowledged with full buffer");
	gc_cmd_next_a: assert property (dec_evt && kind_q == K_ADDR && byte_w == GC_ADDR |=> ack_q && kind_q == K_CMD && !rw_q)
		else $error("general call not taken as command");
	data_full_drop_a: assert property (dec_evt && kind_q == K_DATA && !rx_space |=> !ack_q && ($stable(rx_count) || $past(usb_rx_ready_i)))
		else $error("byte taken into full buffer");
	ack_drive_a: assert property (state_q == ST_ACK && scl_fall && !start_w && !stop_w |=> state_q == ST_ACKH && sda_oe_o == ack_q)
		else $error("ninth clock drive wrong");
	query_set_a: assert property (dec_evt && kind_q == K_CMD && byte_w == CMD_DATA_AVAIL |=> query_q)
		else $error("data-available command not latched");
	sat_value_a: assert property (tx_load && query_q && tx_count >= TX_CNT_W'(SAT_LIMIT) && !start_w && !stop_w |=> !sda_oe_o && shift_q == 8'hFE)
		else $error("count not saturated");
	flush_empty_a: assert property (flush_w |=> tx_count == '0 && rx_count == '0)
		else $error("buffers not flushed");
	unknown_cmd_a: assert property (dec_evt && kind_q == K_CMD && byte_w != CMD_DATA_AVAIL && byte_w != CMD_FLUSH
		&& byte_w != CMD_SOFT_RESET |-> !flush_w ##1 query_q == $past(query_q))
		else $error("unknown command had an effect");
	tx_status_a: assert property (tx_count != '0 |=> !tx_buffer_has_data_n_o)
		else $error("transmit status not active");
	rx_status_a: assert property (rx_count == RX_CNT_W'(RX_DEPTH) |=> rx_buffer_has_space_n_o)
		else $error("receive status active while full");
	cover_gc_cmd: cover property (dec_evt && kind_q == K_CMD);
	cover_rx_push: cover property (dec_evt && dec_push);
	cover_tx_burst: cover property (state_q == ST_MACK && tx_load);
	cover_addr10: cover property (dec_evt && kind_q == K_ADDR2 && dec_a10);
endmodule : i2c_slave_fifo_bridge

// file: i2c_master_model.sv
// Purpose: Behavioural I2C master facing the bridge
// Assumes: SDA is open drain with a pull-up, SCL is driven by this model only
// Notes: Every bus phase lasts PHASE system clocks; SCL stands high between frames
`timescale 1ns/1ns
module i2c_master_model #(
	parameter int PHASE = 3
) (
	input wire logic clk_i, // System clock
	input wire logic sda_oe_i, // Slave pulls SDA low
	output logic scl_o, // Bus clock
	output logic sda_line_o // Resolved SDA level
);
	logic pull_q;

	// Wired-and of both pullers against the pull-up
	assign sda_line_o = !(sda_oe_i | pull_q);

	initial begin
		scl_o = 1'b1;
		pull_q = 1'b0;
	end

	task automatic gap();
		repeat (PHASE) @(negedge clk_i);
	endtask : gap

	// Start, or repeated start when SCL is low
	task automatic start();
		pull_q = 1'b0;
		gap();
		scl_o = 1'b1;
		gap();
		pull_q = 1'b1;
		gap();
		scl_o = 1'b0;
		gap();
	endtask : start

	// Stop leaves both lines released and high
	task automatic stop();
		pull_q = 1'b1;
		gap();
		scl_o = 1'b1;
		gap();
		pull_q = 1'b0;
		gap();
	endtask : stop

	// One clock pulse; data only changes while SCL is low
	task automatic bit_io(input logic b, output logic r);
		pull_q = !b;
		gap();
		scl_o = 1'b1;
		gap();
		r = sda_line_o;
		scl_o = 1'b0;
		gap();
	endtask : bit_io

	// Eight bits MSB first, then the ninth bit driven by the receiver
	task automatic xfer(input logic [7:0] wb, input logic nin, output logic [7:0] rb, output logic nout);
		for (int i = 7; i >= 0; i--) begin
			bit_io(wb[i], rb[i]);
		end
		bit_io(nin, nout);
	endtask : xfer
endmodule : i2c_master_model

// file: i2c_slave_fifo_bridge_bench.sv
// Purpose: Self-checking bench of the I2C slave bridge
// Assumes: Slave address 0x25 in 7-bit mode and 0x2A5 in 10-bit mode
// Notes: Inputs change at the falling clock edge
`timescale 1ns/1ns
module i2c_slave_fifo_bridge_bench;
	import i2c_bridge_pkg::*;
	localparam logic [7:0] AW = 8'h4A;
	localparam logic [7:0] AR = 8'h4B;
	localparam logic [7:0] HW = 8'hF4;
	localparam logic [7:0] A2 = 8'hA5;
	localparam int TIMEOUT = 70000;
	logic clk_i, rst_n_i, scl, sda, sda_oe, sda_val, a10, tx_v, tx_r, rx_v, rx_r, tx_n, rx_n, pin;
	logic [1:0] sel;
	logic [9:0] saddr;
	logic [7:0] tx_d, rx_d, rb;
	logic ack_n;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;

	i2c_master_model i_i2c_master_model (.clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_line_o(sda));

	i2c_slave_fifo_bridge i_i2c_slave_fifo_bridge (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_val), .sda_oe_o(sda_oe), .slave_addr_i(saddr), .addr_10bit_i(a10), .io_pin_sel_i(sel),
		.usb_tx_valid_i(tx_v), .usb_tx_ready_o(tx_r), .usb_tx_data_i(tx_d), .usb_rx_valid_o(rx_v),
		.usb_rx_ready_i(rx_r), .usb_rx_data_o(rx_d), .tx_buffer_has_data_n_o(tx_n),
		.rx_buffer_has_space_n_o(rx_n), .configurable_io_pin_o(pin));

	// Free-running clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic tally_and_finish();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == TIMEOUT) begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic xb(input logic [7:0] wb, input logic nin);
		i_i2c_master_model.xfer(wb, nin, rb, ack_n);
	endtask : xb

	task automatic addr(input logic [7:0] a);
		i_i2c_master_model.start();
		xb(a, 1'b1);
	endtask : addr

	task automatic stop();
		i_i2c_master_model.stop();
		repeat (2) @(negedge clk_i);
	endtask : stop

	task automatic gc(input logic [7:0] cmd);
		addr(GC_ADDR);
		chk(ack_n, 1'b0);
		xb(cmd, 1'b1);
		chk(ack_n, 1'b0);
		stop();
	endtask : gc

	// Single byte read, master ends it with not-acknowledge
	task automatic read_one();
		addr(AR);
		xb(8'hFF, 1'b1);
		stop();
	endtask : read_one

	task automatic push(input int n, input logic [7:0] base);
		for (int i = 0; i < n; i++) begin
			tx_d = base + i[7:0];
			tx_v = 1'b1;
			@(negedge clk_i);
		end
		tx_v = 1'b0;
		@(negedge clk_i);
	endtask : push

	task automatic pop_chk(input logic [7:0] exp);
		@(negedge clk_i);
		for (int k = 0; k < 20 && rx_v !== 1'b1; k++) @(negedge clk_i);
		chk(rx_v, 1'b1);
		chk(rx_d, exp);
		rx_r = 1'b1;
		@(negedge clk_i);
		rx_r = 1'b0;
	endtask : pop_chk

	task automatic t_reset();
		chk(tx_n, 1'b1);
		chk(rx_n, 1'b0);
		chk(tx_r, 1'b1);
		chk(rx_v, 1'b0);
		chk(sda_oe, 1'b0);
		chk(sda_val, 1'b0);
		chk(pin, 1'b1);
	endtask : t_reset

	task automatic t_write7();
		addr(AW);
		chk(ack_n, 1'b0);
		xb(8'h3C, 1'b1);
		chk(ack_n, 1'b0);
		xb(8'hA5, 1'b1);
		chk(ack_n, 1'b0);
		stop();
		pop_chk(8'h3C);
		pop_chk(8'hA5);
		addr(8'h48);
		chk(ack_n, 1'b1);
		stop();
		// Stored address is configurable: move it and the same byte now matches
		saddr = 10'h024;
		addr(8'h48);
		chk(ack_n, 1'b0);
		stop();
		saddr = 10'h2A5;
	endtask : t_write7

	task automatic t_read();
		addr(AR);
		chk(ack_n, 1'b1);
		stop();
		push(3, 8'h10);
		chk(tx_n, 1'b0);
		sel = 2'h0;
		repeat (2) @(negedge clk_i);
		chk(pin, 1'b0);
		addr(AR);
		chk(ack_n, 1'b0);
		xb(8'hFF, 1'b0);
		chk(rb, 8'h10);
		xb(8'hFF, 1'b0);
		chk(rb, 8'h11);
		xb(8'hFF, 1'b1);
		chk(rb, 8'h12);
		stop();
		chk(tx_n, 1'b1);
	endtask : t_read

	task automatic t_count();
		push(5, 8'h40);
		gc(CMD_DATA_AVAIL);
		read_one();
		chk(rb, 8'h05);
		read_one();
		chk(rb, 8'h40);
		gc(8'h55);
		chk(tx_n, 1'b0);
		addr(AW);
		xb(8'h5A, 1'b1);
		stop();
		gc(CMD_FLUSH);
		chk(tx_n, 1'b1);
		chk(rx_v, 1'b0);
		push(300, 8'h00);
		gc(CMD_DATA_AVAIL);
		read_one();
		chk(rb, 8'hFF);
		gc(CMD_SOFT_RESET);
		chk(tx_n, 1'b1);
	endtask : t_count

	task automatic t_fill();
		int nacks;
		nacks = 0;
		sel = 2'h1;
		addr(AW);
		for (int i = 0; i < RX_DEPTH; i++) begin
			xb(i[7:0], 1'b1);
			nacks += int'(ack_n);
		end
		chk(nacks[7:0], 8'h00);
		xb(8'hEE, 1'b1);
		chk(ack_n, 1'b1);
		stop();
		chk(rx_n, 1'b1);
		chk(pin, 1'b1);
		addr(AW);
		chk(ack_n, 1'b1);
		stop();
		for (int i = 0; i < RX_DEPTH; i++) pop_chk(i[7:0]);
		repeat (2) @(negedge clk_i);
		chk(rx_v, 1'b0);
		chk(rx_n, 1'b0);
		chk(pin, 1'b0);
	endtask : t_fill

	task automatic t_10bit();
		a10 = 1'b1;
		@(negedge clk_i);
		addr(HW);
		chk(ack_n, 1'b0);
		xb(A2, 1'b1);
		chk(ack_n, 1'b0);
		xb(8'h77, 1'b1);
		stop();
		pop_chk(8'h77);
		push(1, 8'h99);
		addr(HW);
		xb(A2, 1'b1);
		addr(8'hF5);
		chk(ack_n, 1'b0);
		xb(8'hFF, 1'b1);
		chk(rb, 8'h99);
		stop();
		addr(HW);
		xb(8'hA4, 1'b1);
		chk(ack_n, 1'b1);
		stop();
	endtask : t_10bit

	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		a10 = 1'b0;
		sel = 2'h2;
		saddr = 10'h2A5;
		tx_v = 1'b0;
		tx_d = 8'h00;
		rx_r = 1'b0;
		repeat (16) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (2) @(negedge clk_i);
		t_reset();
		t_write7();
		t_read();
		t_count();
		t_fill();
		t_10bit();
		tally_and_finish();
	end
endmodule : i2c_slave_fifo_bridge_bench
